//--- design/imr_pkg.sv
// package: constants and types for the indirect move / return execution block
`default_nettype none
package imr_pkg;
    localparam int PTR_W = 16;
    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam int STACK_DEPTH = 16;
    // opcode selector of the execution unit
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_STORE_IND = 3'b001,
        OP_STORE_REL = 3'b010,
        OP_NOP = 3'b011,
        OP_SWRESET = 3'b100,
        OP_RETINT = 3'b101
    } imr_op_type;
    typedef enum logic [1:0] {
        MODE_PRE_INC = 2'b00,
        MODE_PRE_DEC = 2'b01,
        MODE_POST_INC = 2'b10,
        MODE_POST_DEC = 2'b11
    } imr_mode_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REFETCH = 2'b01
    } imr_state_type;
    // register map (APB byte addresses)
    localparam logic [11:0] ADDR_CMD = 12'h000;
    localparam logic [11:0] ADDR_PTR0 = 12'h004;
    localparam logic [11:0] ADDR_PTR1 = 12'h008;
    localparam logic [11:0] ADDR_WREG = 12'h00C;
    localparam logic [11:0] ADDR_PC = 12'h010;
    localparam logic [11:0] ADDR_INTCTL = 12'h014;
    localparam logic [11:0] ADDR_PWRCTL = 12'h018;
    localparam logic [11:0] ADDR_STATUS = 12'h01C;
    localparam logic [11:0] ADDR_MEMDATA = 12'h020;
    localparam logic [11:0] ADDR_PUSH = 12'h024;
    // command word fields, then control register bit positions and register reset values
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SEL_BIT = 3;
    localparam int CMD_MODE_LSB = 4;
    localparam int CMD_OFS_LSB = 8;
    localparam int OFS_W = 6;
    localparam int GIE_BIT = 7;
    localparam int RESET_FLAG_BIT = 2;
    localparam logic [DATA_W-1:0] INTCTL_RST = 8'h00;
    localparam logic [DATA_W-1:0] PWRCTL_RST = 8'h04;
    localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
endpackage
`default_nettype wire

//--- design/imr_stack_if.sv
// interface: return stack push/pop between core and stack module
`default_nettype none
interface imr_stack_if;
    logic push;
    logic pop;
    logic [imr_pkg::PC_W-1:0] pushData;
    logic [imr_pkg::PC_W-1:0] topOfStack;
    logic empty;
    modport core (output push, output pop, output pushData, input topOfStack, input empty);
    modport stack (input push, input pop, input pushData, output topOfStack, output empty);
endinterface
`default_nettype wire

//--- design/imr_return_stack.sv
// hardware return stack with circular depth
`default_nettype none
module imr_return_stack #(
    parameter int DEPTH = imr_pkg::STACK_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    imr_stack_if.stack stk
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("stack depth must be a power of two >= 2");
    end
    logic [imr_pkg::PC_W-1:0] mem [DEPTH];
    logic [AW-1:0] ptr;
    logic [AW-1:0] next_ptr;
    logic [AW:0] fill;
    logic [AW:0] next_fill;
    // wraps on overflow, as a fixed-depth hardware stack does
    always_comb begin
        next_ptr = ptr;
        next_fill = fill;
        if (stk.push) begin
            next_ptr = ptr + 1'b1;
            if (fill != (AW+1)'(DEPTH)) next_fill = fill + 1'b1;
        end else if (stk.pop) begin
            next_ptr = ptr - 1'b1;
            if (fill != '0) next_fill = fill - 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= '0;
            fill <= '0;
        end else begin
            ptr <= next_ptr;
            fill <= next_fill;
        end
    end
    always_ff @(posedge core_clk) begin
        if (stk.push) mem[next_ptr] <= stk.pushData;
    end
    assign stk.topOfStack = mem[ptr];
    assign stk.empty = (fill == '0);
endmodule // imr_return_stack
`default_nettype wire

//--- design/imr_exec_unit.sv
// execution unit: indirect store, no-op, software reset, return from interrupt
// Operation
// - Store-indirect copies the working register to the memory word addressed through a pointer alias.
// - Pointer mode 00 pre-increments, 01 pre-decrements, 10 post-increments, 11 post-decrements.
// - The indirect alias holds nothing; its access goes to the address held in the selected pointer.
// - Pointers span 0000h to FFFFh and wrap modulo 65536 on increment or decrement.
// - Pointer auto-update during an indirect store leaves all status flags untouched.
// - Software reset raises a one-cycle reset request (softResetReq) and clears the reset-instruction flag.
// - Return from interrupt sets the global interrupt enable at bit 7 of interrupt control.
// - Relative-offset store addresses pointer plus signed offset -32..31 and leaves the pointer unchanged.
`default_nettype none
module imr_exec_unit #(
    parameter int MEM_WORDS = 256
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy,
    output logic softResetReq,
    output logic globalIntEnable
);
    localparam int MAW = $clog2(MEM_WORDS);
    // folding onto the low address bits needs a power-of-two depth, else the index runs past the array
    if (MEM_WORDS < 2 || MEM_WORDS > 65536 || (1 << MAW) != MEM_WORDS) begin : g_bad_mem_words
        $error("MEM_WORDS must be a power of two from 2 to 65536");
    end

    ////////////////////////////////////////////////////////////////////////////
    imr_stack_if stk ();
    imr_return_stack #(.DEPTH(imr_pkg::STACK_DEPTH)) u_stack (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .stk(stk)
    );

    function automatic logic [imr_pkg::PTR_W-1:0] ptrStep(input logic [imr_pkg::PTR_W-1:0] p, input logic dec);
        ptrStep = dec ? p - 1'b1 : p + 1'b1;
    endfunction

    logic [imr_pkg::DATA_W-1:0] mem [MEM_WORDS];
    logic [imr_pkg::PTR_W-1:0] ptr0, ptr1, next_ptr0, next_ptr1;
    logic [imr_pkg::DATA_W-1:0] wreg, next_wreg;
    logic [imr_pkg::PC_W-1:0] pc, next_pc;
    logic [imr_pkg::DATA_W-1:0] intCtl, next_intCtl;
    logic [imr_pkg::DATA_W-1:0] pwrCtl, next_pwrCtl;
    logic [imr_pkg::DATA_W-1:0] status, next_status;
    logic [imr_pkg::PTR_W-1:0] memAddr, next_memAddr;
    logic softRst, next_softRst;
    imr_pkg::imr_state_type state, next_state;

    logic wrEn, rdEn;
    logic cmdWr;
    imr_pkg::imr_op_type op;
    imr_pkg::imr_mode_type mode;
    logic sel;
    logic [imr_pkg::OFS_W-1:0] ofs;
    logic [imr_pkg::PTR_W-1:0] curPtr, stepped, effAddr;
    logic memWe;

    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !penable && !pwrite;
    assign cmdWr = wrEn && paddr == imr_pkg::ADDR_CMD && state == imr_pkg::ST_IDLE;
    assign op = imr_pkg::imr_op_type'(pwdata[imr_pkg::CMD_OP_LSB +: 3]);
    assign mode = imr_pkg::imr_mode_type'(pwdata[imr_pkg::CMD_MODE_LSB +: 2]);
    assign sel = pwdata[imr_pkg::CMD_SEL_BIT];
    assign ofs = pwdata[imr_pkg::CMD_OFS_LSB +: imr_pkg::OFS_W];
    // the alias has no storage: the selected pointer is the address
    assign curPtr = sel ? ptr1 : ptr0;
    assign stepped = ptrStep(curPtr, mode[0]);
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign busy = (state == imr_pkg::ST_REFETCH);
    assign softResetReq = softRst;
    assign globalIntEnable = intCtl[imr_pkg::GIE_BIT];
    assign stk.pushData = pwdata[imr_pkg::PC_W-1:0];
    assign stk.push = wrEn && paddr == imr_pkg::ADDR_PUSH;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        effAddr = curPtr;
        unique case (mode)
            imr_pkg::MODE_PRE_INC, imr_pkg::MODE_PRE_DEC: effAddr = stepped;
            imr_pkg::MODE_POST_INC, imr_pkg::MODE_POST_DEC: effAddr = curPtr;
        endcase
        // signed 6-bit offset, sign extended onto 16 bits
        if (op == imr_pkg::OP_STORE_REL) begin
            effAddr = curPtr + {{(imr_pkg::PTR_W-imr_pkg::OFS_W){ofs[imr_pkg::OFS_W-1]}}, ofs};
        end
    end

    always_comb begin
        next_ptr0 = ptr0;
        next_ptr1 = ptr1;
        next_wreg = wreg;
        next_pc = pc;
        next_intCtl = intCtl;
        next_pwrCtl = pwrCtl;
        next_status = status;
        next_memAddr = memAddr;
        next_softRst = 1'b0;
        next_state = state;
        memWe = 1'b0;
        stk.pop = 1'b0;
        if (wrEn && state == imr_pkg::ST_IDLE) begin
            unique case (paddr)
                imr_pkg::ADDR_PTR0: next_ptr0 = pwdata[imr_pkg::PTR_W-1:0];
                imr_pkg::ADDR_PTR1: next_ptr1 = pwdata[imr_pkg::PTR_W-1:0];
                imr_pkg::ADDR_WREG: next_wreg = pwdata[imr_pkg::DATA_W-1:0];
                imr_pkg::ADDR_PC: next_pc = pwdata[imr_pkg::PC_W-1:0];
                imr_pkg::ADDR_INTCTL: next_intCtl = pwdata[imr_pkg::DATA_W-1:0];
                imr_pkg::ADDR_PWRCTL: next_pwrCtl = pwdata[imr_pkg::DATA_W-1:0];
                imr_pkg::ADDR_STATUS: next_status = pwdata[imr_pkg::DATA_W-1:0];
                imr_pkg::ADDR_MEMDATA: next_memAddr = pwdata[imr_pkg::PTR_W-1:0];
                default: ;
            endcase
        end
        if (cmdWr) begin
            unique case (op)
                imr_pkg::OP_STORE_IND: begin
                    memWe = 1'b1;
                    next_pc = pc + 1'b1;
                    if (sel) next_ptr1 = stepped;
                    else next_ptr0 = stepped;
                end
                imr_pkg::OP_STORE_REL: begin
                    memWe = 1'b1;
                    next_pc = pc + 1'b1;
                end
                imr_pkg::OP_NOP: next_pc = pc + 1'b1;
                imr_pkg::OP_SWRESET: begin
                    next_softRst = 1'b1;
                    next_pwrCtl[imr_pkg::RESET_FLAG_BIT] = 1'b0;
                end
                imr_pkg::OP_RETINT: begin
                    stk.pop = 1'b1;
                    next_pc = stk.topOfStack;
                    next_intCtl[imr_pkg::GIE_BIT] = 1'b1;
                    next_state = imr_pkg::ST_REFETCH;
                end
                default: ;
            endcase
        end else if (state == imr_pkg::ST_REFETCH) begin
            next_state = imr_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr0 <= '0;
            ptr1 <= '0;
            wreg <= '0;
            pc <= '0;
            intCtl <= imr_pkg::INTCTL_RST;
            pwrCtl <= imr_pkg::PWRCTL_RST;
            status <= imr_pkg::STATUS_RST;
            memAddr <= '0;
            softRst <= 1'b0;
            state <= imr_pkg::ST_IDLE;
        end else begin
            ptr0 <= next_ptr0;
            ptr1 <= next_ptr1;
            wreg <= next_wreg;
            pc <= next_pc;
            intCtl <= next_intCtl;
            pwrCtl <= next_pwrCtl;
            status <= next_status;
            memAddr <= next_memAddr;
            softRst <= next_softRst;
            state <= next_state;
        end
    end

    // memory beyond MEM_WORDS aliases onto the low address bits
    always_ff @(posedge core_clk) begin
        if (memWe) mem[effAddr[MAW-1:0]] <= wreg;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) prdata <= '0;
        else if (rdEn) begin
            unique case (paddr)
                imr_pkg::ADDR_PTR0: prdata <= {16'h0000, ptr0};
                imr_pkg::ADDR_PTR1: prdata <= {16'h0000, ptr1};
                imr_pkg::ADDR_WREG: prdata <= {24'h000000, wreg};
                imr_pkg::ADDR_PC: prdata <= {17'h0, pc};
                imr_pkg::ADDR_INTCTL: prdata <= {24'h000000, intCtl};
                imr_pkg::ADDR_PWRCTL: prdata <= {24'h000000, pwrCtl};
                imr_pkg::ADDR_STATUS: prdata <= {24'h000000, status};
                imr_pkg::ADDR_MEMDATA: prdata <= {24'h000000, mem[memAddr[MAW-1:0]]};
                imr_pkg::ADDR_CMD: prdata <= {31'h0, busy};
                default: prdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence retIssued;
        cmdWr && op == imr_pkg::OP_RETINT;
    endsequence
    chk_ret_loads_pc: assert property (@(posedge core_clk) disable iff (!rst_n)
        retIssued |=> pc == $past(stk.topOfStack)) else $error("pc not loaded from stack top");
    chk_ret_sets_gie: assert property (@(posedge core_clk) disable iff (!rst_n)
        retIssued |=> globalIntEnable) else $error("global enable not set");
    chk_ret_two_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
        retIssued |=> busy ##1 !busy) else $error("return not two cycles");
    chk_ptr_wrap_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmdWr && op == imr_pkg::OP_STORE_IND && !sel |=>
        ptr0 == ($past(mode[0]) ? $past(ptr0) - 16'h0001 : $past(ptr0) + 16'h0001))
        else $error("pointer step wrong");
    chk_pre_post_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmdWr && op == imr_pkg::OP_STORE_IND |-> effAddr == (mode[1] ? curPtr : stepped))
        else $error("pre/post address wrong");
    chk_status_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmdWr && op == imr_pkg::OP_STORE_IND |=> $stable(status)) else $error("status changed");
    chk_rel_ptr_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmdWr && op == imr_pkg::OP_STORE_REL |=> $stable(ptr0) && $stable(ptr1))
        else $error("relative store moved pointer");
    chk_swreset_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmdWr && op == imr_pkg::OP_SWRESET |=> softResetReq && !pwrCtl[imr_pkg::RESET_FLAG_BIT])
        else $error("software reset effect missing");
    chk_nop_pc_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmdWr && op == imr_pkg::OP_NOP |=> pc == $past(pc) + 15'h0001 && $stable(wreg) && $stable(ptr0))
        else $error("no-op changed state");
    chk_store_data: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmdWr && op == imr_pkg::OP_STORE_IND |=> mem[$past(effAddr[MAW-1:0])] == $past(wreg))
        else $error("stored data wrong");
endmodule // imr_exec_unit
`default_nettype wire

//--- verification/tb.sv
// testbench: register-level checks of the indirect move / return execution block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
        $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

    logic core_clk = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, busy, softResetReq, globalIntEnable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, pcNow;
    int error_cnt = 0;
    int compares = 0;
    int busyCycles = 0;
    int pulseCycles = 0;
    int busyBase = 0;
    int pulseBase = 0;
    logic [7:0] eaTab [4] = '{8'h81, 8'h7F, 8'h80, 8'h80};
    logic [15:0] epTab [4] = '{16'h0081, 16'h007F, 16'h0081, 16'h007F};

    imr_exec_unit #(.MEM_WORDS(256)) imr_exec_unit_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy), .softResetReq(softResetReq), .globalIntEnable(globalIntEnable));

    always #25 core_clk = ~core_clk;

    // pulse widths seen at the clock, counted so one-cycle outputs are not missed
    always @(posedge core_clk) begin
        if (busy === 1'b1) busyCycles++;
        if (softResetReq === 1'b1) pulseCycles++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("errors %0d, comparisons %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: no pready", $time);
            end_of_test();
        end else begin
            r = prdata;
            `CHK(pslverr, 1'b0)
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        apb(1'b0, a, 32'h0, x);
        `CHK(x, e)
    endtask

    function automatic logic [31:0] cmd(imr_pkg::imr_op_type op, logic sel, logic [1:0] m, logic [5:0] ofs);
        return {18'h0, ofs, 2'b00, m, sel, op};
    endfunction

    // loads pointer and working reg, runs one store, checks pointer, target byte, flags and counter
    task automatic store(input logic [31:0] c, input logic [11:0] pa, input logic [15:0] p0,
                         input logic [7:0] ea, input logic [15:0] ep, input logic [7:0] w);
        logic [31:0] pc0;
        wr(pa, {16'h0, p0});
        wr(imr_pkg::ADDR_WREG, {24'h0, w});
        apb(1'b0, imr_pkg::ADDR_PC, 32'h0, pc0);
        wr(imr_pkg::ADDR_CMD, c);
        rdc(pa, {16'h0, ep});
        wr(imr_pkg::ADDR_MEMDATA, {24'h0, ea});
        rdc(imr_pkg::ADDR_MEMDATA, {24'h0, w});
        rdc(imr_pkg::ADDR_STATUS, 32'h000000A5);
        rdc(imr_pkg::ADDR_PC, {17'h0, pc0[14:0] + 15'h0001});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rdc(imr_pkg::ADDR_PWRCTL, {24'h0, imr_pkg::PWRCTL_RST});
        rdc(imr_pkg::ADDR_INTCTL, {24'h0, imr_pkg::INTCTL_RST});
        rdc(12'h030, 32'h0);
        // non-zero flags, so a stray clear by a pointer step shows
        wr(imr_pkg::ADDR_STATUS, 32'h000000A5);
        for (int m = 0; m < 4; m++) begin
            store(cmd(imr_pkg::OP_STORE_IND, m[0], m[1:0], 6'h00), m[0] ? imr_pkg::ADDR_PTR1 : imr_pkg::ADDR_PTR0,
                  16'h0080, eaTab[m], epTab[m], 8'(8'hA0 + m));
        end
        // pointer wrap at both ends of the 16-bit range
        store(cmd(imr_pkg::OP_STORE_IND, 1'b0, 2'b00, 6'h00), imr_pkg::ADDR_PTR0, 16'hFFFF, 8'h00, 16'h0000, 8'h5A);
        store(cmd(imr_pkg::OP_STORE_IND, 1'b1, 2'b11, 6'h00), imr_pkg::ADDR_PTR1, 16'h0000, 8'h00, 16'hFFFF, 8'hC3);
        store(cmd(imr_pkg::OP_STORE_IND, 1'b0, 2'b01, 6'h00), imr_pkg::ADDR_PTR0, 16'h0000, 8'hFF, 16'hFFFF, 8'h3C);
        // offset extremes; mode bits set to show they are ignored
        store(cmd(imr_pkg::OP_STORE_REL, 1'b1, 2'b11, 6'h20), imr_pkg::ADDR_PTR1, 16'h0150, 8'h30, 16'h0150, 8'h11);
        store(cmd(imr_pkg::OP_STORE_REL, 1'b0, 2'b00, 6'h1F), imr_pkg::ADDR_PTR0, 16'hFFF0, 8'h0F, 16'hFFF0, 8'h22);
        apb(1'b0, imr_pkg::ADDR_PC, 32'h0, pcNow);
        wr(imr_pkg::ADDR_CMD, cmd(imr_pkg::OP_NOP, 1'b0, 2'b00, 6'h00));
        rdc(imr_pkg::ADDR_PC, {17'h0, pcNow[14:0] + 15'h0001});
        rdc(imr_pkg::ADDR_PTR0, 32'h0000FFF0);
        rdc(imr_pkg::ADDR_WREG, 32'h00000022);
        rdc(imr_pkg::ADDR_INTCTL, 32'h0);
        wr(imr_pkg::ADDR_PUSH, 32'h00001234);
        busyBase = busyCycles;
        wr(imr_pkg::ADDR_CMD, cmd(imr_pkg::OP_RETINT, 1'b0, 2'b00, 6'h00));
        rdc(imr_pkg::ADDR_PC, 32'h00001234);
        `CHK(busyCycles - busyBase, 1)
        rdc(imr_pkg::ADDR_CMD, 32'h0);
        `CHK(globalIntEnable, 1'b1)
        rdc(imr_pkg::ADDR_INTCTL, 32'h00000080);
        pulseBase = pulseCycles;
        wr(imr_pkg::ADDR_CMD, cmd(imr_pkg::OP_SWRESET, 1'b0, 2'b00, 6'h00));
        rdc(imr_pkg::ADDR_PWRCTL, 32'h0);
        `CHK(pulseCycles - pulseBase, 1)
        // the system answers the request by pulling reset
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rdc(imr_pkg::ADDR_INTCTL, 32'h0);
        `CHK(globalIntEnable, 1'b0)
        rdc(imr_pkg::ADDR_PC, 32'h0);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
